/* File: dv/pcl_link_asserts.sv */
// checks on the configuration link between host and device
`timescale 1ns/1ps
`default_nettype none
`include "pcl_params.svh"
module pcl_link_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reconfig_request_low,
  input wire logic config_clock,
  input wire logic [31:0] data,
  input wire logic status_in,
  input wire logic load_complete_in,
  input wire logic init_done_in
);
  logic [9:0] rises;
  logic clk_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ****
  // helpers
  // ****
  // counts only rises after status is up, so power-on edges are excluded
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rises <= 10'h000;
      clk_q <= 1'b0;
    end else begin
      clk_q <= config_clock;
      if (!status_in || !reconfig_request_low)
        rises <= 10'h000;
      else if (config_clock && !clk_q)
        rises <= rises + 10'h001;
    end
  end
  // ****
  // properties
  // ****
  AST_USER_HIGH: assert property (
    reconfig_request_low && load_complete_in |-> status_in)
    else $error("status low while configured");
  AST_REQ_STATUS: assert property (
    $fell(reconfig_request_low) |-> ##[0:64] !status_in)
    else $error("no status drop after request");
  AST_DATA_HOLD: assert property (
    config_clock |-> $stable(data))
    else $error("data moved while clock high");
  AST_DONE_COUNT: assert property (
    $rose(load_complete_in) |-> rises >= `PCL_IMG_WORDS)
    else $error("done before all words clocked");
  AST_DONE_STATUS: assert property (
    $rose(load_complete_in) |-> status_in && reconfig_request_low)
    else $error("done during error or request");
  AST_TAIL_FALLS: assert property (
    $rose(load_complete_in) |->
      ##[0:40] $fell(config_clock) ##[1:8] $fell(config_clock))
    else $error("two falling edges missing");
  AST_CLK_PARKED: assert property (
    (reconfig_request_low && load_complete_in && !config_clock) [*8]
      |=> !config_clock)
    else $error("clock moved after load");
  AST_INIT_AFTER_DONE: assert property (
    $rose(init_done_in) |-> load_complete_in)
    else $error("init released before done");
  cover property ($rose(load_complete_in));
  cover property ($fell(reconfig_request_low));
  cover property ($rose(init_done_in));
endmodule
`default_nettype wire

/* File: dv/test_parallel_config_load_port.sv */
// self-checking bench joining host and device across the link
`timescale 1ns/1ps
`default_nettype none
`include "pcl_params.svh"
module test_parallel_config_load_port;
  import pcl_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dec = 1'b0;
  logic sec = 1'b0;
  logic w16 = 1'b0;
  logic init_en = 1'b0;
  logic in_user_mode;
  logic [31:0] last_word;
  logic [31:0] pw = 32'h0;
  logic [31:0] msk = 32'hff;
  logic [31:0] pv = 32'h0;
  integer seed = 32'hceec;
  integer mismatches = 0;
  integer checked = 0;
  logic [31:0] q[$];
  pcl_link_if link();
  pcl_host pcl_host_i (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  pcl_device pcl_device_i (.mclk(mclk), .rst_b(rst_b), .link(link),
    .decomp_en(dec), .secure_en(sec), .width16(w16),
    .init_done_en(init_en), .in_user_mode(in_user_mode),
    .last_word(last_word));
  pcl_link_asserts pcl_link_asserts_i (.mclk(mclk), .rst_b(rst_b),
    .reconfig_request_low(link.reconfig_request_low),
    .config_clock(link.config_clock), .data(link.data),
    .status_in(link.status_in), .load_complete_in(link.load_complete_in),
    .init_done_in(link.init_done_in));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // refused data writes are retried, so a full word register is exercised
  task automatic load(input logic [31:0] c);
    logic [31:0] rd;
    logic err;
    logic [31:0] w;
    apb(1'b1, `PCL_ADDR_CTRL, c | 32'h1, rd, err);
    for (int i = 0; i < `PCL_IMG_WORDS; i++) begin
      if (i == 8) begin
        apb(1'b1, `PCL_ADDR_CTRL, c | 32'h10, rd, err);
        repeat (40) @(posedge mclk);
        chk("paused", 32'h0, {31'h0, link.config_clock});
        apb(1'b1, `PCL_ADDR_CTRL, c, rd, err);
      end
      w = $random(seed);
      // the monitor sees words by change, so no two in a row are equal
      if (((w ^ pv) & msk) == 32'h0)
        w = w ^ 32'h1;
      pv = w & msk;
      q.push_back(w & msk);
      err = 1'b1;
      while (err) apb(1'b1, `PCL_ADDR_DATA, w, rd, err);
    end
    while (q.size() != 0 || in_user_mode !== 1'b1) @(posedge mclk);
    // let the host finish its tail clocks and go idle
    repeat (40) @(posedge mclk);
    apb(1'b0, `PCL_ADDR_STAT, 32'h0, rd, err);
    chk("stat", 32'h3e, {26'h0, rd[5:0]});
    chk("left", 32'h0, q.size());
  endtask
  // ****
  // monitor and sequence
  // ****
  always @(posedge mclk) begin
    if (!rst_b)
      pw <= last_word;
    else if (last_word !== pw) begin
      pw <= last_word;
      chk("word", q.size() ? q.pop_front() : 32'hx, last_word);
    end
    if (link.config_clock === 1'b1)
      chk("upper", 32'h0, link.data & ~msk);
  end
  initial begin
    logic [2:0] modes [6] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h6, 3'h5};
    logic [31:0] rd;
    logic err;
    for (int m = 0; m < 6; m++) begin
      rst_b <= 1'b0;
      pv = 32'h0;
      {w16, sec, dec} <= modes[m];
      rd = $random(seed);
      init_en <= rd[0];
      msk <= modes[m][2] ? 32'hffff : 32'hff;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, 12'h00c, 32'h0, rd, err);
      chk("unmapped", 32'h1, {31'h0, err});
      load({28'h0, modes[m], 1'b0});
      load({28'h0, modes[m], 1'b0});
      $display("test %0d done", m);
    end
    conclude();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire

/* File: hw/pcl_device.sv */
// device end: accepts the parallel configuration stream
`timescale 1ns/1ps
`default_nettype none
`include "pcl_params.svh"
module pcl_device
  import pcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  pcl_link_if.device link,
  input wire logic decomp_en,
  input wire logic secure_en,
  input wire logic width16,
  input wire logic init_done_en,
  output logic in_user_mode,
  output logic [31:0] last_word
);
  // ****************************************
  // device state
  // ****************************************
  typedef struct packed {
    logic [1:0] req_sync;
    logic [15:0] por_cnt;
    pcl_dev_state_t state;
    logic [2:0] sub;
    logic [15:0] words;
    logic [1:0] falls;
    logic [7:0] init_cnt;
    logic user;
    logic [31:0] last;
  } pcl_dev_t;
  pcl_dev_t r;
  pcl_dev_t next_r;
  logic [2:0] ratio;
  logic [31:0] mask;

  always_comb begin
    next_r = r;
    ratio = pcl_ratio(width16, decomp_en, secure_en);
    mask = width16 ? 32'h0000ffff : 32'h000000ff;
    next_r.req_sync = {r.req_sync[0], link.reconfig_request_low};
    case (r.state)
      PCL_DEV_POR: begin
        if (r.por_cnt != 16'h0000)
          next_r.por_cnt = r.por_cnt - 16'h0001;
        else if (r.req_sync[1])
          next_r.state = PCL_DEV_LOAD;
      end
      PCL_DEV_LOAD: begin
        // a word is taken on the last of its r rising edges
        if (r.sub + 3'h1 >= ratio) begin
          next_r.sub = 3'h0;
          next_r.last = link.data & mask;
          next_r.words = r.words + 16'h0001;
          if (r.words + 16'h0001 == 16'(`PCL_IMG_WORDS))
            next_r.state = PCL_DEV_DONE;
        end else begin
          next_r.sub = r.sub + 3'h1;
        end
      end
      PCL_DEV_DONE: begin
        // counted on rising edges; falls in between are implied
        next_r.falls = r.falls + 2'h1;
        if (r.falls + 2'h1 == 2'(`PCL_TAIL_FALLS)) begin
          next_r.state = PCL_DEV_INIT;
          next_r.init_cnt = 8'(`PCL_INIT_CYC);
        end
      end
      PCL_DEV_INIT: begin
        if (r.init_cnt != 8'h00)
          next_r.init_cnt = r.init_cnt - 8'h01;
        else begin
          next_r.state = PCL_DEV_USER;
          next_r.user = 1'b1;
        end
      end
      PCL_DEV_USER: ;
      default: next_r.state = PCL_DEV_POR;
    endcase
    // reconfiguration drops user mode from any state once the request is through req_sync
    if (!r.req_sync[1]) begin
      next_r.state = PCL_DEV_POR;
      next_r.user = 1'b0;
      next_r.sub = 3'h0;
      next_r.words = 16'h0000;
      next_r.falls = 2'h0;
    end
  end

  always_ff @(posedge link.config_clock or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.req_sync <= 2'b11;
      r.state <= PCL_DEV_POR;
      r.por_cnt <= 16'(`PCL_POR_CYC);
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // pins, all open-drain, low while busy
  // ****************************************
  always_ff @(posedge link.config_clock or negedge rst_b) begin
    if (!rst_b) begin
      link.status_oe <= 1'b1;
      link.load_complete_oe <= 1'b1;
      link.init_done_oe <= 1'b0;
      in_user_mode <= 1'b0;
      last_word <= 32'h00000000;
    end else begin
      link.status_oe <= next_r.state == PCL_DEV_POR;
      link.load_complete_oe <= next_r.state == PCL_DEV_POR ||
        next_r.state == PCL_DEV_LOAD;
      link.init_done_oe <= init_done_en &&
        next_r.state != PCL_DEV_USER;
      in_user_mode <= next_r.user;
      last_word <= next_r.last;
    end
  end
  assign link.status_o = 1'b0;
  assign link.load_complete_o = 1'b0;
  assign link.init_done_o = 1'b0;
endmodule
`default_nettype wire

/* File: hw/pcl_host.sv */
// host end: APB-controlled loader that makes the configuration clock
`timescale 1ns/1ps
`default_nettype none
`include "pcl_params.svh"
// How it works
// - low request starts a new configuration
// - user mode: status, done, request high
// - status low through power-on delay
// - done low until all data taken
// - clock driven low after configuration
// - each word held r clocks
// - pause holds the clock low
// - data valid before first rising edge
// - host sends the whole image
// - done high only after all words
// - two falling edges after done; the host gives PCL_TAIL_RUN (14)
// - init output low until initialised; the device leaves it high from reset until the first config_clock rise
// - ratio from width and features
// - only low 8 or 16 lines driven; the host drives all 32 data lines, with the upper ones held at 0
module pcl_host
  import pcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pcl_link_if.host link
);
  // ****************************************
  // host state
  // ****************************************
  typedef struct packed {
    logic [4:0] ctrl;
    logic [31:0] word;
    logic word_full;
    logic [15:0] sent;
    pcl_hst_state_t state;
    logic [1:0] div;
    logic clk;
    logic [2:0] sub;
    logic [4:0] falls;
    logic req_low;
    logic [31:0] dout;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [1:0] st_sync;
    logic [1:0] cd_sync;
    logic [1:0] id_sync;
  } pcl_hst_t;
  pcl_hst_t r;
  pcl_hst_t next_r;
  logic [2:0] ratio;
  logic [31:0] mask;
  logic access;
  logic commit;
  logic edge_due;

  always_comb begin
    next_r = r;
    ratio = pcl_ratio(r.ctrl[`PCL_CTRL_W16], r.ctrl[`PCL_CTRL_DECOMP],
      r.ctrl[`PCL_CTRL_SECURE]);
    mask = r.ctrl[`PCL_CTRL_W16] ? 32'h0000ffff : 32'h000000ff;
    // answer on the second access edge, writes land with pready
    access = psel && penable && !r.ready;
    commit = psel && penable && r.ready && !r.err;
    next_r.st_sync = {r.st_sync[0], link.status_in};
    next_r.cd_sync = {r.cd_sync[0], link.load_complete_in};
    next_r.id_sync = {r.id_sync[0], link.init_done_in};
    next_r.ready = access;
    next_r.err = 1'b0;
    next_r.rdata = 32'h00000000;
    // ****************************************
    // apb slave, one wait state
    // ****************************************
    if (access) begin
      case (paddr)
        `PCL_ADDR_CTRL: next_r.rdata = {27'h0, r.ctrl};
        `PCL_ADDR_STAT: next_r.rdata = {26'h0, !r.word_full,
          r.state == PCL_HST_IDLE && r.cd_sync[1] && r.st_sync[1],
          r.id_sync[1], r.cd_sync[1], r.st_sync[1],
          r.state != PCL_HST_IDLE};
        `PCL_ADDR_DATA: next_r.err = pwrite && r.word_full;
        default: next_r.err = 1'b1;
      endcase
    end
    // word_full only clears meanwhile, so the refusal made above still holds
    if (commit && pwrite) begin
      if (paddr == `PCL_ADDR_CTRL)
        next_r.ctrl = pwdata[4:0];
      else if (paddr == `PCL_ADDR_DATA) begin
        next_r.word = pwdata & mask;
        next_r.word_full = 1'b1;
      end
    end
    // ****************************************
    // link sequencer; clock runs at mclk / 4
    // ****************************************
    edge_due = r.div == 2'(`PCL_DIV_HALF - 1);
    next_r.div = edge_due ? 2'h0 : r.div + 2'h1;
    case (r.state)
      PCL_HST_IDLE: begin
        next_r.clk = 1'b0;
        if (r.ctrl[`PCL_CTRL_START]) begin
          next_r.ctrl[`PCL_CTRL_START] = 1'b0;
          next_r.req_low = 1'b1;
          next_r.sent = 16'h0000;
          next_r.state = PCL_HST_REQ;
        end
      end
      PCL_HST_REQ: begin
        // device samples the request on the link clock, so keep it running
        if (edge_due)
          next_r.clk = !r.clk;
        // hold request until device shows it has reset
        if (!r.st_sync[1]) begin
          next_r.req_low = 1'b0;
          next_r.state = PCL_HST_WAIT;
        end
      end
      PCL_HST_WAIT: begin
        if (r.st_sync[1]) begin
          next_r.state = PCL_HST_LOAD;
          next_r.sub = 3'h0;
          next_r.clk = 1'b0;
        end else if (edge_due) begin
          // power-on delay counts on this clock
          next_r.clk = !r.clk;
        end
      end
      PCL_HST_LOAD: begin
        if (edge_due) begin
          if (r.clk) begin
            next_r.clk = 1'b0;
            if (r.sub == ratio) begin
              next_r.sub = 3'h0;
              next_r.sent = r.sent + 16'h0001;
              if (r.sent + 16'h0001 == 16'(`PCL_IMG_WORDS)) begin
                next_r.state = PCL_HST_TAIL;
                next_r.falls = 5'h00;
              end
            end else begin
              next_r.sub = r.sub + 3'h1;
            end
          end else if (r.sub == 3'h0) begin
            // load a fresh word while clock is low, before its rise
            if (r.word_full && !r.ctrl[`PCL_CTRL_PAUSE]) begin
              next_r.dout = r.word;
              next_r.word_full = 1'b0;
              next_r.sub = 3'h1;
            end
          end else begin
            next_r.clk = 1'b1;
          end
        end
      end
      PCL_HST_TAIL: begin
        // clocks until done seen, then PCL_TAIL_RUN (14) falling edges
        if (edge_due) begin
          next_r.clk = !r.clk;
          if (r.clk && r.cd_sync[1]) begin
            next_r.falls = r.falls + 5'h01;
            if (r.falls + 5'h01 == 5'(`PCL_TAIL_RUN))
              next_r.state = PCL_HST_END;
          end
        end
      end
      PCL_HST_END: begin
        next_r.clk = 1'b0;
        next_r.state = PCL_HST_IDLE;
      end
      default: next_r.state = PCL_HST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.state <= PCL_HST_IDLE;
      r.st_sync <= 2'b11;
      r.cd_sync <= 2'b11;
      r.id_sync <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    prdata = r.rdata;
    pready = r.ready;
    pslverr = r.err;
    link.reconfig_request_low = !r.req_low;
    link.config_clock = r.clk;
    link.data = r.dout;
  end
endmodule
`default_nettype wire

/* File: hw/pcl_link_if.sv */
// link between configuration host and device
`timescale 1ns/1ps
`default_nettype none
interface pcl_link_if;
  logic reconfig_request_low;
  logic config_clock;
  logic [31:0] data;
  logic status_o;
  logic status_oe;
  logic load_complete_o;
  logic load_complete_oe;
  logic init_done_o;
  logic init_done_oe;
  logic status_in;
  logic load_complete_in;
  logic init_done_in;
  // open-drain lines with pull-ups
  assign status_in = status_oe ? status_o : 1'b1;
  assign load_complete_in = load_complete_oe ? load_complete_o : 1'b1;
  assign init_done_in = init_done_oe ? init_done_o : 1'b1;
  modport device (input reconfig_request_low, input config_clock,
    input data, output status_o, output status_oe, output load_complete_o,
    output load_complete_oe, output init_done_o, output init_done_oe,
    input status_in);
  modport host (output reconfig_request_low, output config_clock,
    output data, input status_in, input load_complete_in,
    input init_done_in);
endinterface
`default_nettype wire

/* File: hw/pcl_params.svh */
// timing and layout constants for the parallel configuration load port
`ifndef PCL_PARAMS_SVH
`define PCL_PARAMS_SVH
`define PCL_POR_NS 2000
`define PCL_MCLK_NS 25
`define PCL_POR_CYC ((`PCL_POR_NS + `PCL_MCLK_NS - 1) / `PCL_MCLK_NS)
`define PCL_IMG_WORDS 16
`define PCL_INIT_CYC 8
`define PCL_DIV_HALF 2
`define PCL_TAIL_FALLS 2
// the device has no clock but the link clock, so it must run on through init
`define PCL_TAIL_RUN (`PCL_TAIL_FALLS + `PCL_INIT_CYC + 4)
`define PCL_ADDR_CTRL 12'h000
`define PCL_ADDR_STAT 12'h004
`define PCL_ADDR_DATA 12'h008
`define PCL_CTRL_START 0
`define PCL_CTRL_DECOMP 1
`define PCL_CTRL_SECURE 2
`define PCL_CTRL_W16 3
`define PCL_CTRL_PAUSE 4
`define PCL_ST_BUSY 0
`define PCL_ST_STATUS 1
`define PCL_ST_DONE 2
`define PCL_ST_INIT 3
`define PCL_ST_USER 4
`define PCL_ST_WRDY 5
`endif

/* File: hw/pcl_pkg.sv */
// types shared by both ends of the configuration load port
package pcl_pkg;
  typedef enum logic [4:0] {
    PCL_DEV_POR = 5'h01,
    PCL_DEV_LOAD = 5'h02,
    PCL_DEV_DONE = 5'h04,
    PCL_DEV_INIT = 5'h08,
    PCL_DEV_USER = 5'h10
  } pcl_dev_state_t;
  typedef enum logic [5:0] {
    PCL_HST_IDLE = 6'h01,
    PCL_HST_REQ = 6'h02,
    PCL_HST_WAIT = 6'h04,
    PCL_HST_LOAD = 6'h08,
    PCL_HST_TAIL = 6'h10,
    PCL_HST_END = 6'h20
  } pcl_hst_state_t;
  // cycles per word from width and features
  function automatic logic [2:0] pcl_ratio(input logic w16,
      input logic decomp, input logic secure);
    if (decomp)
      return w16 ? 3'h4 : 3'h2;
    else if (secure && w16)
      return 3'h2;
    else
      return 3'h1;
  endfunction
endpackage
